// ===== logic/spp_sink_power.sv
// Sink power profile control: settings, load phase and power-path gate.
//
// Behaviour
// - Decode current code, flexible at zero.
// - Flexible current resets to 200 steps.
// - Profile one detach 3.3V, attach minus 20%.
// - High-voltage-only: enable only on profile two/three.
// - Mismatch under high-voltage-only keeps path open.
// - New successful negotiation then enables path.
// - Close path when bus within attach limits; profile one uses minus 20%, not 3.3V.
// - Load all registers from memory on reset, except profile one voltage, which stays 5 V.
// - Load phase ends within 30 ms.
// - Power-on reset release starts load phase.
// - External reset release starts load phase.
// - Profile one is always 5 V.
// - Without high-voltage-only, enable whenever attached and bus within limits.
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module spp_sink_power #(
	parameter int LOAD_CYCLES = spp_pkg::LOAD_CYCLES
)
(
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Internal power-on reset, active low.
	input wire logic por_n,
	// Non-volatile memory defaults.
	input wire logic [31:0] nvm_ctrl,
	input wire logic [31:0] nvm_pdo1,
	input wire logic [31:0] nvm_pdo2,
	input wire logic [31:0] nvm_pdo3,
	// Link status from the negotiation engine.
	input wire logic source_attached,
	input wire logic contract_valid,
	input wire logic [1:0] contract_profile,
	input wire logic [9:0] bus_voltage,
	// AXI4-Lite slave.
	input wire logic [7:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [7:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	// Outputs.
	output logic sink_power_path_enable,
	output logic load_busy,
	output logic [9:0] bus_low_monitor_limit,
	output logic [9:0] bus_high_monitor_limit
);

	////////////////////////////////////////////////////////////////////////////////
	// Decoding helpers.

	// Current in 10 mA steps.
	function automatic logic [9:0] decode_current(input logic [3:0] code, input logic [9:0] flex);
		logic [9:0] r;
		r = 10'h000;
		case (code)
			4'h0: r = flex;
			4'h1: r = 10'h032;
			4'h2: r = 10'h04b;
			4'h3: r = 10'h064;
			4'h4: r = 10'h07d;
			4'h5: r = 10'h096;
			4'h6: r = 10'h0af;
			4'h7: r = 10'h0c8;
			4'h8: r = 10'h0e1;
			4'h9: r = 10'h0fa;
			4'ha: r = 10'h113;
			4'hb: r = 10'h12c;
			4'hc: r = 10'h15e;
			4'hd: r = 10'h190;
			4'he: r = 10'h1c2;
			4'hf: r = 10'h1f4;
			default: r = 10'h000;
		endcase
		return r;
	endfunction

	function automatic logic [9:0] pct_of(input logic [9:0] v, input int pct);
		logic [19:0] p;
		p = 20'(v) * 20'(pct);
		return 10'(p / 20'd100);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Settings and load phase.

	logic [2:0] wr_sel;
	logic hvo_reg;
	logic [1:0] count_reg;
	logic [9:0] flex_reg [3];
	logic [3:0] code_reg [3];
	logic [9:0] volt_reg [3];
	logic [31:0] load_cnt_reg;
	spp_pkg::spp_state_t state_reg;
	logic bus_wr;
	logic [7:0] aw_addr_reg;
	logic aw_have_reg;
	logic [31:0] w_data_reg;
	logic w_have_reg;
	logic in_range;
	logic profile_ok;

	assign load_busy = (state_reg == spp_pkg::PH_LOAD);

	// Load counter; the longest load fits the deadline by construction.
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !por_n)
			load_cnt_reg <= 32'h0;
		else if (state_reg == spp_pkg::PH_LOAD)
			load_cnt_reg <= load_cnt_reg + 32'h1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !por_n)
			state_reg <= spp_pkg::PH_LOAD;
		else
			case (state_reg)
				spp_pkg::PH_LOAD:
					if (load_cnt_reg >= 32'(LOAD_CYCLES - 1))
						state_reg <= spp_pkg::PH_IDLE;
				spp_pkg::PH_IDLE:
					if (source_attached)
						state_reg <= spp_pkg::PH_ATTACHED;
				spp_pkg::PH_ATTACHED:
					if (!source_attached || bus_voltage < spp_pkg::DETACH_3V3)
						state_reg <= spp_pkg::PH_IDLE;
				default:
					state_reg <= spp_pkg::PH_LOAD;
			endcase
	end

	// A write taken as the power-on reset falls would otherwise be answered inside the load.
	assign bus_wr = aw_have_reg && w_have_reg && !s_bvalid && !load_busy && por_n;
	assign wr_sel = (aw_addr_reg == spp_pkg::ADDR_PDO1) ? 3'h1 :
		(aw_addr_reg == spp_pkg::ADDR_PDO2) ? 3'h2 :
		(aw_addr_reg == spp_pkg::ADDR_PDO3) ? 3'h4 : 3'h0;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			hvo_reg <= spp_pkg::HVO_RESET;
			count_reg <= spp_pkg::COUNT_RESET;
		end
		else if (load_cnt_reg == 32'h0 && state_reg == spp_pkg::PH_LOAD)
		begin
			hvo_reg <= nvm_ctrl[spp_pkg::CTRL_HVO_BIT];
			count_reg <= nvm_ctrl[spp_pkg::CTRL_CNT_LSB +: 2];
		end
		else if (bus_wr && aw_addr_reg == spp_pkg::ADDR_CTRL && s_wstrb[0])
		begin
			hvo_reg <= w_data_reg[spp_pkg::CTRL_HVO_BIT];
			count_reg <= w_data_reg[spp_pkg::CTRL_CNT_LSB +: 2];
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_pdo
			logic [31:0] nv;
			assign nv = (gi == 0) ? nvm_pdo1 : (gi == 1) ? nvm_pdo2 : nvm_pdo3;
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					flex_reg[gi] <= spp_pkg::FLEX_RESET;
					code_reg[gi] <= spp_pkg::CODE_RESET;
					volt_reg[gi] <= (gi == 0) ? spp_pkg::VOLT_5V :
						(gi == 1) ? spp_pkg::VOLT_15V : spp_pkg::VOLT_20V;
				end
				else if (load_cnt_reg == 32'h0 && state_reg == spp_pkg::PH_LOAD)
				begin
					flex_reg[gi] <= nv[spp_pkg::PDO_FLEX_LSB +: 10];
					code_reg[gi] <= nv[spp_pkg::PDO_CODE_LSB +: 4];
					volt_reg[gi] <= (gi == 0) ? spp_pkg::VOLT_5V :
						nv[spp_pkg::PDO_VOLT_LSB +: 10];
				end
				else if (bus_wr && wr_sel[gi])
				begin
					if (s_wstrb[0])
						flex_reg[gi][7:0] <= w_data_reg[7:0];
					if (s_wstrb[1])
					begin
						flex_reg[gi][9:8] <= w_data_reg[9:8];
						code_reg[gi] <= w_data_reg[15:12];
					end
					// Profile one voltage is fixed, so its voltage field ignores writes.
					if (gi != 0 && s_wstrb[2])
						volt_reg[gi][7:0] <= w_data_reg[23:16];
					if (gi != 0 && s_wstrb[3])
						volt_reg[gi][9:8] <= w_data_reg[25:24];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Monitor limits and power path.

	logic [1:0] idx;
	logic [9:0] nom;
	logic [9:0] low_attach;
	logic [9:0] high_limit;
	assign idx = (contract_valid && contract_profile != 2'h0 && contract_profile <= count_reg) ?
		2'(contract_profile - 2'h1) : 2'h0;
	assign nom = volt_reg[idx];
	// The window check uses the live limits, so a new profile is not judged by the old one.
	assign low_attach = 10'(nom - pct_of(nom, spp_pkg::UNDER_PCT));
	assign high_limit = 10'(nom + pct_of(nom, (idx == 2'h0) ?
		spp_pkg::OVER1_PCT : spp_pkg::OVER_PCT));

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bus_low_monitor_limit <= 10'h000;
			bus_high_monitor_limit <= 10'h3ff;
		end
		else
		begin
			// Profile one detach uses the fixed floor; attach uses the margin.
			if (idx == 2'h0 && state_reg == spp_pkg::PH_ATTACHED)
				bus_low_monitor_limit <= spp_pkg::DETACH_3V3;
			else
				bus_low_monitor_limit <= low_attach;
			bus_high_monitor_limit <= high_limit;
		end
	end

	assign in_range = bus_voltage >= low_attach && bus_voltage <= high_limit &&
		bus_voltage >= spp_pkg::DETACH_3V3;
	// A new contract is re-evaluated every cycle, so a later success enables the path.
	assign profile_ok = !hvo_reg ||
		(contract_valid && idx != 2'h0);

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !por_n)
			sink_power_path_enable <= 1'b0;
		else if (state_reg != spp_pkg::PH_ATTACHED || !source_attached)
			sink_power_path_enable <= 1'b0;
		else
			sink_power_path_enable <= profile_ok && in_range;
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave; writes are held back during the load phase.

	logic ar_ok;
	logic [31:0] rd_mux;
	assign s_awready = !aw_have_reg;
	assign s_wready = !w_have_reg;
	assign s_arready = !s_rvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0;
			s_bvalid <= 1'b0;
			s_bresp <= spp_pkg::RESP_OKAY;
		end
		else
		begin
			if (s_awvalid && s_awready)
			begin
				aw_have_reg <= 1'b1;
				aw_addr_reg <= s_awaddr;
			end
			if (s_wvalid && s_wready)
			begin
				w_have_reg <= 1'b1;
				w_data_reg <= s_wdata;
			end
			if (bus_wr)
			begin
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				s_bvalid <= 1'b1;
				s_bresp <= (aw_addr_reg == spp_pkg::ADDR_CTRL || wr_sel != 3'h0) ?
					spp_pkg::RESP_OKAY : spp_pkg::RESP_SLVERR;
			end
			else if (s_bvalid && s_bready)
				s_bvalid <= 1'b0;
		end
	end

	always_comb
	begin
		ar_ok = 1'b1;
		rd_mux = 32'h0;
		case (s_araddr)
			spp_pkg::ADDR_CTRL: rd_mux = {26'h0, count_reg, 3'h0, hvo_reg};
			spp_pkg::ADDR_PDO1: rd_mux = {6'h0, volt_reg[0], code_reg[0], 2'h0, flex_reg[0]};
			spp_pkg::ADDR_PDO2: rd_mux = {6'h0, volt_reg[1], code_reg[1], 2'h0, flex_reg[1]};
			spp_pkg::ADDR_PDO3: rd_mux = {6'h0, volt_reg[2], code_reg[2], 2'h0, flex_reg[2]};
			spp_pkg::ADDR_STAT: rd_mux = {28'h0, state_reg == spp_pkg::PH_ATTACHED,
				sink_power_path_enable, load_busy, contract_valid};
			spp_pkg::ADDR_CUR: rd_mux = {22'h0, decode_current(code_reg[idx], flex_reg[idx])};
			default: ar_ok = 1'b0;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_rvalid <= 1'b0;
			s_rdata <= 32'h0;
			s_rresp <= spp_pkg::RESP_OKAY;
		end
		else if (s_arvalid && s_arready)
		begin
			s_rvalid <= 1'b1;
			s_rdata <= rd_mux;
			s_rresp <= ar_ok ? spp_pkg::RESP_OKAY : spp_pkg::RESP_SLVERR;
		end
		else if (s_rvalid && s_rready)
			s_rvalid <= 1'b0;
	end

endmodule

// ===== logic/spp_pkg.sv
// Package of constants and types for the sink power profile control block.
package spp_pkg;
	// Register byte offsets.
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_PDO1 = 8'h04;
	localparam logic [7:0] ADDR_PDO2 = 8'h08;
	localparam logic [7:0] ADDR_PDO3 = 8'h0c;
	localparam logic [7:0] ADDR_STAT = 8'h10;
	localparam logic [7:0] ADDR_CUR = 8'h14;
	// Control register fields.
	localparam int CTRL_HVO_BIT = 0;
	localparam int CTRL_CNT_LSB = 4;
	// Profile register fields.
	localparam int PDO_FLEX_LSB = 0;
	localparam int PDO_CODE_LSB = 12;
	localparam int PDO_VOLT_LSB = 16;
	// Reset values.
	localparam logic [9:0] FLEX_RESET = 10'h0c8;
	localparam logic [3:0] CODE_RESET = 4'h0;
	localparam logic HVO_RESET = 1'b0;
	localparam logic [1:0] COUNT_RESET = 2'h3;
	// Bus voltages in 50 mV units.
	localparam logic [9:0] VOLT_5V = 10'h064;
	localparam logic [9:0] VOLT_15V = 10'h12c;
	localparam logic [9:0] VOLT_20V = 10'h190;
	localparam logic [9:0] DETACH_3V3 = 10'h042;
	// Monitor margins in percent.
	localparam int UNDER_PCT = 20;
	localparam int OVER1_PCT = 15;
	localparam int OVER_PCT = 10;
	// Load phase time.
	localparam int LOAD_MS = 30;
	localparam int CLK_HZ = 10000000;
	localparam int LOAD_CYCLES = LOAD_MS * (CLK_HZ / 1000);
	// AXI responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {PH_LOAD, PH_IDLE, PH_ATTACHED} spp_state_t;
endpackage

// ===== dv/spp_properties.sv
// Checker of load phase and power-path timing at the block's ports.
`timescale 1ns/1ps
module spp_checker #(
	parameter int LOAD_CYCLES = spp_pkg::LOAD_CYCLES
)
(
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic por_n,
	// Link status.
	input wire logic source_attached,
	input wire logic [9:0] bus_voltage,
	// Bus handshakes.
	input wire logic s_arvalid,
	input wire logic s_arready,
	input wire logic s_rvalid,
	input wire logic s_rready,
	input wire logic s_bvalid,
	// Outputs.
	input wire logic sink_power_path_enable,
	input wire logic load_busy
);
	logic [31:0] busy_cnt;
	// A delay range cannot span the full default load, so the cycles are counted here.
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !por_n || !load_busy)
			busy_cnt <= 32'h0;
		else
			busy_cnt <= busy_cnt + 32'h1;
	end
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////////////////////
	a_load_path_off: assert property (load_busy |-> !sink_power_path_enable)
		else $error("path enabled during load");
	a_detach_low: assert property ((bus_voltage < 10'h042) |=> !sink_power_path_enable)
		else $error("path enabled below detach level");
	a_detach_off: assert property (!source_attached |=> !sink_power_path_enable)
		else $error("path enabled while detached");
	a_por_load: assert property (!por_n |=> load_busy)
		else $error("no load after power-on reset");
	a_ext_load: assert property ($rose(aresetn) |-> load_busy)
		else $error("no load after reset release");
	a_load_bound: assert property (load_busy |-> busy_cnt < 32'(LOAD_CYCLES))
		else $error("load phase too long");
	a_write_held: assert property (load_busy |-> !s_bvalid)
		else $error("write answered during load");
	a_read_answer: assert property ((s_arvalid && s_arready) |=> s_rvalid)
		else $error("read not answered");
	a_read_hold: assert property ((s_rvalid && !s_rready) |=> s_rvalid)
		else $error("read data dropped");
	cover property ($fell(load_busy));
	cover property ($rose(sink_power_path_enable));
	cover property ($fell(sink_power_path_enable) && source_attached);
endmodule

bind spp_sink_power spp_checker #(.LOAD_CYCLES(LOAD_CYCLES)) spp_checker_inst (.*);

// ===== dv/spp_source.sv
// Model of the power source at the far end of the link.
`timescale 1ns/1ps
module spp_source (
	// Clock.
	input wire logic aclk,
	// Link status.
	output logic source_attached,
	output logic contract_valid,
	output logic [1:0] contract_profile,
	output logic [9:0] bus_voltage
);
	initial
	begin
		source_attached = 1'b0;
		contract_valid = 1'b0;
		contract_profile = 2'h1;
		bus_voltage = 10'h000;
	end
	// A source always starts at 5 V with no contract.
	task automatic attach();
		source_attached <= 1'b1;
		bus_voltage <= spp_pkg::VOLT_5V;
	endtask
	task automatic detach();
		source_attached <= 1'b0;
		contract_valid <= 1'b0;
	endtask
	// A slow source drops the old contract first, leaving a gap with the cable still attached.
	task automatic offer(input logic [1:0] p, input logic [9:0] v, input int w);
		if (w > 0)
			contract_valid <= 1'b0;
		repeat (w) @(posedge aclk);
		contract_profile <= p;
		bus_voltage <= v;
		contract_valid <= 1'b1;
	endtask
endmodule

// ===== dv/tb.sv
// Testbench of the sink power profile control block.
`timescale 1ns/1ps
module tb;
	localparam int LC = 20;
	logic aclk, aresetn, por_n, source_attached, contract_valid;
	logic [31:0] nvm_ctrl, nvm_pdo1, nvm_pdo2, nvm_pdo3, s_wdata, s_rdata, rdata_q;
	logic [1:0] contract_profile, s_bresp, s_rresp, resp_q;
	logic [9:0] bus_voltage, bus_low_monitor_limit, bus_high_monitor_limit;
	logic [7:0] s_awaddr, s_araddr;
	logic [3:0] s_wstrb;
	logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
	logic s_arvalid, s_arready, s_rvalid, s_rready, sink_power_path_enable, load_busy;
	logic [9:0] lut [16] = '{10'h07b, 10'h032, 10'h04b, 10'h064, 10'h07d, 10'h096, 10'h0af,
		10'h0c8, 10'h0e1, 10'h0fa, 10'h113, 10'h12c, 10'h15e, 10'h190, 10'h1c2, 10'h1f4};
	int mismatches = 0;
	int num_checks = 0;
	spp_sink_power #(.LOAD_CYCLES(LC)) spp_sink_power_inst (.*);
	spp_source spp_source_inst (.*);
	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic close_out(input int e);
		mismatches += e;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		for (n = 0; n < 99 && !(s_bvalid === 1'b1 && n > 0); n++)
		begin
			@(posedge aclk);
			if (s_awready && s_awvalid)
				s_awvalid <= 1'b0;
			if (s_wready && s_wvalid)
				s_wvalid <= 1'b0;
		end
		resp_q = s_bresp;
		if (n == 99)
			close_out(1);
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		for (n = 0; n < 99 && !(s_rvalid === 1'b1 && n > 0); n++)
		begin
			@(posedge aclk);
			if (s_arready && s_arvalid)
				s_arvalid <= 1'b0;
		end
		rdata_q = s_rdata;
		resp_q = s_rresp;
		if (n == 99)
			close_out(1);
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// Drives one reset source low for h edges, then waits out the load phase.
	task automatic reload(input logic ext, input int h);
		int n;
		if (ext)
			aresetn <= 1'b0;
		else
			por_n <= 1'b0;
		step(h);
		aresetn <= 1'b1;
		por_n <= 1'b1;
		step(1);
		chk({31'h0, load_busy}, 32'h1);
		chk({31'h0, sink_power_path_enable}, 32'h0);
		for (n = 0; n < LC + 9 && load_busy !== 1'b0; n++)
			step(1);
		chk(32'(n <= LC + 2), 32'h1);
		if (n > LC + 2)
			close_out(0);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		aresetn = 1'b0;
		por_n = 1'b1;
		nvm_ctrl = 32'h0000_0030;
		nvm_pdo1 = 32'h0064_0096;
		nvm_pdo2 = 32'h012c_00c8;
		nvm_pdo3 = 32'h0190_0064;
		s_wstrb = 4'hf;
		{s_awaddr, s_wdata, s_awvalid, s_wvalid, s_bready} = '0;
		{s_araddr, s_arvalid, s_rready} = '0;
		spp_source_inst.attach();
		reload(1'b1, 2);
		step(3);
		chk({31'h0, sink_power_path_enable}, 32'h1);
		rd(spp_pkg::ADDR_CTRL);
		chk(rdata_q, nvm_ctrl);
		rd(spp_pkg::ADDR_PDO2);
		chk(rdata_q, nvm_pdo2);
		wr(spp_pkg::ADDR_PDO1, 32'h012c_0096);
		chk({30'h0, resp_q}, {30'h0, spp_pkg::RESP_OKAY});
		rd(spp_pkg::ADDR_PDO1);
		chk(rdata_q, 32'h0064_0096);
		rd(8'h20);
		chk({30'h0, resp_q}, {30'h0, spp_pkg::RESP_SLVERR});
		wr(8'h20, 32'h0000_0001);
		chk({30'h0, resp_q}, {30'h0, spp_pkg::RESP_SLVERR});
		// The application cannot run at 5 V, so only the higher profiles may power it.
		wr(spp_pkg::ADDR_CTRL, 32'h0000_0031);
		spp_source_inst.offer(2'h1, spp_pkg::VOLT_5V, 0);
		step(4);
		chk({31'h0, sink_power_path_enable}, 32'h0);
		spp_source_inst.offer(2'h2, spp_pkg::VOLT_15V, 6);
		step(4);
		chk({31'h0, sink_power_path_enable}, 32'h1);
		chk({22'h0, bus_low_monitor_limit}, 32'h0f0);
		chk({22'h0, bus_high_monitor_limit}, 32'h14a);
		for (int c = 0; c < 16; c++)
		begin
			wr(spp_pkg::ADDR_PDO2, {6'h0, spp_pkg::VOLT_15V, 4'(c), 12'h07b});
			rd(spp_pkg::ADDR_CUR);
			chk(rdata_q, {22'h0, lut[c]});
		end
		wr(spp_pkg::ADDR_CTRL, nvm_ctrl);
		spp_source_inst.offer(2'h1, spp_pkg::VOLT_5V, 0);
		step(4);
		chk({31'h0, sink_power_path_enable}, 32'h1);
		spp_source_inst.bus_voltage <= 10'h041;
		step(3);
		chk({31'h0, sink_power_path_enable}, 32'h0);
		spp_source_inst.bus_voltage <= spp_pkg::VOLT_5V;
		step(4);
		chk({31'h0, sink_power_path_enable}, 32'h1);
		spp_source_inst.detach();
		step(2);
		chk({31'h0, sink_power_path_enable}, 32'h0);
		reload(1'b0, 1);
		rd(spp_pkg::ADDR_PDO2);
		chk(rdata_q, nvm_pdo2);
		close_out(0);
	end
endmodule
